// ---- rtl/iosd_cfg.svh ----
// address map and timing constants for the i/o space decoder
`ifndef IOSD_CFG_SVH
`define IOSD_CFG_SVH
`define IOSD_MAIN_BASE      32'h0300_0000
`define IOSD_MAIN_LAST      32'h03FF_FFFF
`define IOSD_EXT_BASE       32'h0800_0000
`define IOSD_EXT_LAST       32'h0FFF_FFFF
`define IOSD_EXT_NARROW     32'h08FF_FFFF
`define IOSD_MOD0_BASE      32'h0300_0000
`define IOSD_MOD0_LAST      32'h0300_FFFF
`define IOSD_MOD1_BASE      32'h0303_0000
`define IOSD_MOD1_LAST      32'h0303_FFFF
`define IOSD_MOD_NARROW_SZ  32'h0000_3FFF
`define IOSD_COMBO_BASE     32'h0301_0000
`define IOSD_CDACK_BASE     32'h0301_2000
`define IOSD_CDACK_LAST     32'h0301_2FFF
`define IOSD_CDTC_BASE      32'h0302_A000
`define IOSD_CDTC_LAST      32'h0302_AFFF
`define IOSD_CARDB_BASE     32'h0302_B000
`define IOSD_CARDA_BASE     32'h0302_B800
`define IOSD_CARD_LAST      32'h0302_BFFF
`define IOSD_INT_REG_BASE   32'h0320_0000
`define IOSD_SIO_BASE       32'h0321_0000
`define IOSD_SIO_LAST       32'h033F_FFFF
`define IOSD_VID_REG_BASE   32'h0340_0000
`define IOSD_VID_REG_LAST   32'h034F_FFFF
`define IOSD_SIOB_MASK      32'hFFE7_0000
`define IOSD_SIOB_MATCH     32'h0324_0000
`define IOSD_SIOB_NARROW    32'h0000_C000
`define IOSD_SPD_HI         20
`define IOSD_SPD_LO         19
`define IOSD_LEN_SLOW       3'h7
`define IOSD_LEN_MEDIUM     3'h6
`define IOSD_LEN_FAST       3'h5
`define IOSD_LEN_SYNC       3'h5
`define IOSD_DIV8           2
`define IOSD_IO_RST_HOLD    4'hF
`endif

// ---- rtl/iosd_decode.sv ----
// i/o space decoder and simple 8MHz i/o cycle generator
//
// Function
// - 0x03000000..0x03FFFFFF is main i/o space, decoded by this block
// - extended space from 0x08000000, eight 16MB areas, extended select asserted
// - module select asserted for regions at 0x03000000 and 0x03030000
// - internal register regions 0x03200000 and 0x03400000 drive no external select
// - region 0x03210000 is simple i/o, asserting simple i/o selects
// - strap high narrows module select to two 16KB windows
// - strap high narrows extended select to 0x08000000..0x08FFFFFF
// - strap high: second simple select only in four 16KB windows
// - strap low: module and extended selects cover their whole spaces
// - strap low: second simple select in four 64KB windows
// - fixed-timing 16-bit simple cycles for 0x03210000..0x033FFFFF
// - address bits 20:19 choose length 7, 6, 5 or 5 io cycles
// - writes drive upper 16 data bits onto the i/o bus
// - reads return i/o bus data on lower 16 bits
// - wait/ready input ignored during simple cycles
// - first simple select with read or write strobe, timed from 8MHz clock
// - read strobe for reads, write strobe for writes, both active low
// - sync speed aligns start to the 2MHz output, up to 3 extra cycles
// - handover between bus side and i/o side synchronised at start and end
`timescale 1ns/1ps
`include "iosd_cfg.svh"

module iosd_decode
  import iosd_pkg::*;
(
  // system side
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        req_valid,
  input  iosd_req_s        req,
  output logic             req_done,
  output logic [31:0]      rdata,
  input  wire logic        decode_narrow_strap,
  input  wire logic        ext_ready,
  // decoded selects
  output iosd_sel_s        sel,
  output logic             io_space_hit,
  output logic             int_reg_hit,
  output logic             vid_reg_hit,
  // i/o bus, link clock domain
  input  wire logic        io_clock_in,
  output logic             io_clk_8m_out,
  output logic             io_clk_2m_out,
  output logic             ref_8m_out,
  output logic             simple_io_sel_a_n,
  output logic             simple_io_sel_b_n,
  output logic             io_read_strobe_n,
  output logic             io_write_strobe_n,
  input  wire logic [15:0] io_data_bus_in,
  output logic [15:0]      io_data_bus_out,
  output logic             io_data_bus_oe
);

  // ----------------------------------------------------------------
  // address decode helpers
  // ----------------------------------------------------------------
  function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic siob_hit(input logic [31:0] a, input logic narrow);
    siob_hit = ((a & `IOSD_SIOB_MASK) == `IOSD_SIOB_MATCH)
               && (!narrow || ((a & `IOSD_SIOB_NARROW) == 32'h0000_0000));
  endfunction

  // ----------------------------------------------------------------
  // strap, caught by clock after reset
  // ----------------------------------------------------------------
  logic strap_m_r;
  logic strap_s_r;
  logic strap_t_r;
  logic narrow_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      strap_m_r <= 1'b0;
      strap_s_r <= 1'b0;
      strap_t_r <= 1'b0;
      narrow_r  <= 1'b0;
    end else begin
      strap_m_r <= decode_narrow_strap;
      strap_s_r <= strap_m_r;
      strap_t_r <= strap_s_r;
      if (strap_s_r == strap_t_r) begin
        narrow_r <= strap_t_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // combinational decode of the current request
  // ----------------------------------------------------------------
  logic [31:0] a;
  logic        mod_hit;
  logic        sio_hit;
  logic        siob_now;

  assign a = req.addr;

  always_comb begin
    io_space_hit = req_valid && in_rng(a, `IOSD_MAIN_BASE, `IOSD_MAIN_LAST);
    int_reg_hit  = req_valid && in_rng(a, `IOSD_INT_REG_BASE, `IOSD_SIO_BASE - 32'h1);
    vid_reg_hit  = req_valid && in_rng(a, `IOSD_VID_REG_BASE, `IOSD_VID_REG_LAST);
    if (narrow_r) begin
      mod_hit = in_rng(a, `IOSD_MOD0_BASE, `IOSD_MOD0_BASE + `IOSD_MOD_NARROW_SZ)
             || in_rng(a, `IOSD_MOD1_BASE, `IOSD_MOD1_BASE + `IOSD_MOD_NARROW_SZ);
      sel.ext_space_sel_n = !(req_valid && in_rng(a, `IOSD_EXT_BASE, `IOSD_EXT_NARROW));
    end else begin
      mod_hit = in_rng(a, `IOSD_MOD0_BASE, `IOSD_MOD0_LAST)
             || in_rng(a, `IOSD_MOD1_BASE, `IOSD_MOD1_LAST);
      sel.ext_space_sel_n = !(req_valid && in_rng(a, `IOSD_EXT_BASE, `IOSD_EXT_LAST));
    end
    sel.module_space_sel_n = !(req_valid && mod_hit);
    sel.combo_chip_sel_n   = !(req_valid && in_rng(a, `IOSD_COMBO_BASE, `IOSD_CDACK_BASE - 32'h1));
    sel.combo_dma_ack_n    = !(req_valid && (in_rng(a, `IOSD_CDACK_BASE, `IOSD_CDACK_LAST)
                                          || in_rng(a, `IOSD_CDTC_BASE, `IOSD_CDTC_LAST)));
    sel.terminal_count     = req_valid && in_rng(a, `IOSD_CDTC_BASE, `IOSD_CDTC_LAST);
    sel.card_sel_b_n       = !(req_valid && in_rng(a, `IOSD_CARDB_BASE, `IOSD_CARDA_BASE - 32'h1));
    sel.card_sel_a_n       = !(req_valid && in_rng(a, `IOSD_CARDA_BASE, `IOSD_CARD_LAST));
    sio_hit  = in_rng(a, `IOSD_SIO_BASE, `IOSD_SIO_LAST);
    siob_now = siob_hit(a, narrow_r);
  end

  // ----------------------------------------------------------------
  // system side: launch simple cycle, wait for completion toggle
  // ----------------------------------------------------------------
  logic        busy_r;
  logic        go_tgl_r;
  iosd_req_s   hold_r;
  logic        hold_b_r;
  logic        dn_m_r;
  logic        dn_s_r;
  logic        dn_t_r;
  logic        launch;
  logic        finish;
  logic        io_dn_tgl_r;
  logic [15:0] io_rd_r;

  // module cycles run on another engine; the bus side only waits for simple ones
  assign launch   = req_valid && sio_hit && !busy_r;
  assign finish   = busy_r && (dn_s_r != dn_t_r);
  assign req_done = finish;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy_r   <= 1'b0;
      go_tgl_r <= 1'b0;
      hold_r   <= '0;
      hold_b_r <= 1'b0;
    end else if (launch) begin
      busy_r   <= 1'b1;
      go_tgl_r <= !go_tgl_r;
      hold_r   <= req;
      hold_b_r <= siob_now;
    end else if (finish) begin
      busy_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dn_m_r <= 1'b0;
      dn_s_r <= 1'b0;
      dn_t_r <= 1'b0;
    end else begin
      dn_m_r <= io_dn_tgl_r;
      dn_s_r <= dn_m_r;
      dn_t_r <= dn_s_r;
    end
  end

  // read data is stable in the io domain when the done toggle arrives
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else if (finish && !hold_r.write) begin
      rdata <= {16'h0000, io_rd_r};
    end
  end

  // ----------------------------------------------------------------
  // io domain: clock divider, io_clock_in runs free
  // ----------------------------------------------------------------
  logic [3:0]  rst_hold_r;
  logic        rst_ext_r;
  logic        io_rst_m_r;
  logic        io_rst_s_r;
  logic        io_rst_t_r;
  logic        io_rst_r;
  logic [3:0]  div_r;
  logic        tick8;
  logic        ph2_start;

  // reset is stretched so that a short pulse still spans several io edges
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rst_hold_r <= `IOSD_IO_RST_HOLD;
      rst_ext_r  <= 1'b1;
    end else begin
      if (rst_hold_r != 4'h0) begin
        rst_hold_r <= rst_hold_r - 4'h1;
      end
      rst_ext_r <= (rst_hold_r != 4'h0);
    end
  end

  // io reset follows only once the second and third stages agree
  always_ff @(posedge io_clock_in) begin
    io_rst_m_r <= rst_ext_r;
    io_rst_s_r <= io_rst_m_r;
    io_rst_t_r <= io_rst_s_r;
    if (io_rst_s_r == io_rst_t_r) begin
      io_rst_r <= io_rst_t_r;
    end
  end

  always_ff @(posedge io_clock_in) begin
    if (io_rst_r) begin
      div_r <= 4'h0;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  // div_r[1] is the 8MHz square, div_r[3] the 2MHz square
  assign tick8     = (div_r[1:0] == 2'h3);
  assign ph2_start = (div_r == 4'hF);

  always_ff @(posedge io_clock_in) begin
    if (io_rst_r) begin
      io_clk_8m_out <= 1'b0;
      io_clk_2m_out <= 1'b0;
      ref_8m_out    <= 1'b0;
    end else begin
      io_clk_8m_out <= !div_r[1];
      io_clk_2m_out <= !div_r[3];
      ref_8m_out    <= !div_r[1];
    end
  end

  // ----------------------------------------------------------------
  // io domain: start toggle crossing
  // ----------------------------------------------------------------
  logic go_m_r;
  logic go_s_r;
  logic go_t_r;
  logic io_start;

  always_ff @(posedge io_clock_in) begin
    if (io_rst_r) begin
      go_m_r <= 1'b0;
      go_s_r <= 1'b0;
      go_t_r <= 1'b0;
    end else begin
      go_m_r <= go_tgl_r;
      go_s_r <= go_m_r;
      go_t_r <= go_s_r;
    end
  end

  // ----------------------------------------------------------------
  // io domain: simple cycle state machine
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    IOSD_IDLE   = 5'b00001,
    IOSD_ALIGN  = 5'b00010,
    IOSD_ACTIVE = 5'b00100,
    IOSD_REL    = 5'b01000,
    IOSD_DONE   = 5'b10000
  } iosd_state_e;

  iosd_state_e st_r;
  logic [2:0]  cnt_r;
  logic [2:0]  len;
  logic        pend_r;

  always_comb begin
    case (iosd_speed_e'(hold_r.addr[`IOSD_SPD_HI:`IOSD_SPD_LO]))
      IOSD_SLOW:   len = `IOSD_LEN_SLOW;
      IOSD_MEDIUM: len = `IOSD_LEN_MEDIUM;
      IOSD_FAST:   len = `IOSD_LEN_FAST;
      default:     len = `IOSD_LEN_SYNC;
    endcase
  end

  always_ff @(posedge io_clock_in) begin
    if (io_rst_r) begin
      pend_r <= 1'b0;
    end else if (go_s_r != go_t_r) begin
      pend_r <= 1'b1;
    end else if (st_r == IOSD_IDLE && tick8) begin
      pend_r <= 1'b0;
    end
  end

  // hold_r is steady from launch until done returns, so io side may read it
  always_ff @(posedge io_clock_in) begin
    if (io_rst_r) begin
      st_r        <= IOSD_IDLE;
      cnt_r       <= 3'h0;
      io_dn_tgl_r <= 1'b0;
      io_rd_r     <= 16'h0000;
    end else begin
      case (st_r)
        IOSD_IDLE: begin
          if (pend_r && tick8) begin
            cnt_r <= 3'h1;
            // already on a 2MHz boundary: no wait, so at most 3 ticks are added
            if (hold_r.addr[`IOSD_SPD_HI:`IOSD_SPD_LO] == 2'h3 && !ph2_start) begin
              st_r <= IOSD_ALIGN;
            end else begin
              st_r <= IOSD_ACTIVE;
            end
          end
        end
        IOSD_ALIGN: begin
          if (ph2_start) begin
            st_r <= IOSD_ACTIVE;
          end
        end
        IOSD_ACTIVE: begin
          if (tick8) begin
            cnt_r <= cnt_r + 3'h1;
            if (cnt_r == len - 3'h1) begin
              st_r <= IOSD_REL;
            end
          end
        end
        IOSD_REL: begin
          // the read strobe pin rises on this edge, so the bus is taken as it releases
          if (!hold_r.write && !io_read_strobe_n) begin
            io_rd_r <= io_data_bus_in;
          end
          if (tick8) begin
            st_r <= IOSD_DONE;
          end
        end
        IOSD_DONE: begin
          if (tick8) begin
            io_dn_tgl_r <= !io_dn_tgl_r;
            st_r        <= IOSD_IDLE;
          end
        end
        default: st_r <= IOSD_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // io domain: pin drive
  // ----------------------------------------------------------------
  logic in_cyc;
  logic strobe;

  assign in_cyc = (st_r == IOSD_ACTIVE) || (st_r == IOSD_REL);
  assign strobe = (st_r == IOSD_ACTIVE) && (cnt_r != 3'h1);

  always_ff @(posedge io_clock_in) begin
    if (io_rst_r) begin
      simple_io_sel_a_n <= 1'b1;
      simple_io_sel_b_n <= 1'b1;
      io_read_strobe_n  <= 1'b1;
      io_write_strobe_n <= 1'b1;
      io_data_bus_out   <= 16'h0000;
      io_data_bus_oe    <= 1'b0;
    end else begin
      simple_io_sel_a_n <= !in_cyc;
      simple_io_sel_b_n <= !(in_cyc && hold_b_r);
      io_read_strobe_n  <= !(strobe && !hold_r.write);
      io_write_strobe_n <= !(strobe && hold_r.write);
      io_data_bus_out   <= hold_r.wdata[31:16];
      io_data_bus_oe    <= in_cyc && hold_r.write;
    end
  end

endmodule // iosd_decode

// ---- rtl/iosd_pkg.sv ----
// types shared by the i/o space decoder
package iosd_pkg;
  typedef enum logic [1:0] {
    IOSD_SLOW   = 2'h0,
    IOSD_MEDIUM = 2'h1,
    IOSD_FAST   = 2'h2,
    IOSD_SYNC   = 2'h3
  } iosd_speed_e;
  typedef struct packed {
    logic module_space_sel_n;
    logic ext_space_sel_n;
    logic combo_chip_sel_n;
    logic combo_dma_ack_n;
    logic terminal_count;
    logic card_sel_a_n;
    logic card_sel_b_n;
  } iosd_sel_s;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        write;
  } iosd_req_s;
endpackage

// ---- tb/iosd_decode_asserts.sv ----
// port checks for the i/o space decoder
`timescale 1ns/1ps
module iosd_decode_asserts
  import iosd_pkg::*;
(
  // system side
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        req_valid,
  input iosd_req_s        req,
  input wire logic        req_done,
  input wire logic [31:0] rdata,
  input iosd_sel_s        sel,
  input wire logic        io_space_hit,
  input wire logic        int_reg_hit,
  // i/o side
  input wire logic        io_clock_in,
  input wire logic        io_clk_8m_out,
  input wire logic        io_clk_2m_out,
  input wire logic        ref_8m_out,
  input wire logic        simple_io_sel_a_n,
  input wire logic        io_read_strobe_n,
  input wire logic        io_write_strobe_n,
  input wire logic [15:0] io_data_bus_out,
  input wire logic        io_data_bus_oe
);
  // --
  // select low time in link clocks
  // --
  logic [5:0] low_cnt_r;
  logic [5:0] min_cnt;
  assign min_cnt = (req.addr[20:19] == 2'h0) ? 6'h1C : (req.addr[20:19] == 2'h1) ? 6'h18 : 6'h14;
  always_ff @(posedge io_clock_in) begin
    if (rst || simple_io_sel_a_n) low_cnt_r <= 6'h00;
    else low_cnt_r <= low_cnt_r + 6'h01;
  end
  // --
  // checks
  // --
  main_space_a: assert property (@(posedge clk_sys) disable iff (rst)
    req_valid |-> io_space_hit == (req.addr[31:24] == 8'h03)) else $error("main space hit wrong");
  ext_space_a: assert property (@(posedge clk_sys) disable iff (rst)
    req_valid && req.addr[31:24] == 8'h08 |-> !sel.ext_space_sel_n) else $error("ext select missing");
  ext_none_a: assert property (@(posedge clk_sys) disable iff (rst)
    req_valid && req.addr[31:27] != 5'h01 |-> sel.ext_space_sel_n) else $error("ext select stray");
  module_sel_a: assert property (@(posedge clk_sys) disable iff (rst)
    req_valid && req.addr[31:16] inside {16'h0300, 16'h0303} && req.addr[15:14] == 2'h0
    |-> !sel.module_space_sel_n) else $error("module select missing");
  dack_tc_a: assert property (@(posedge clk_sys) disable iff (rst)
    req_valid && req.addr[31:12] == 20'h0302A |-> !sel.combo_dma_ack_n && sel.terminal_count)
    else $error("dack or tc missing");
  int_quiet_a: assert property (@(posedge clk_sys) disable iff (rst)
    req_valid && req.addr[31:16] == 16'h0320 |-> int_reg_hit && sel == 7'h7B) else $error("internal region wrong");
  done_range_a: assert property (@(posedge clk_sys) disable iff (rst)
    req_done |-> req_valid && req.addr >= 32'h0321_0000 && req.addr <= 32'h033F_FFFF) else $error("done out of range");
  rd_upper_a: assert property (@(posedge clk_sys) disable iff (rst)
    req_done && !req.write |=> rdata[31:16] == 16'h0000) else $error("read upper half set");
  strobe_sel_a: assert property (@(posedge io_clock_in) disable iff (rst)
    !io_read_strobe_n || !io_write_strobe_n |-> !simple_io_sel_a_n && (io_read_strobe_n || io_write_strobe_n))
    else $error("strobe without select");
  wr_drive_a: assert property (@(posedge io_clock_in) disable iff (rst)
    !io_write_strobe_n |-> io_data_bus_oe && io_data_bus_out == req.wdata[31:16]) else $error("write data wrong");
  rd_float_a: assert property (@(posedge io_clock_in) disable iff (rst)
    !io_read_strobe_n |-> !io_data_bus_oe) else $error("bus driven on read");
  sel_after_a: assert property (@(posedge io_clock_in) disable iff (rst)
    !$past(io_read_strobe_n) && io_read_strobe_n |-> !simple_io_sel_a_n) else $error("select left early");
  cycle_len_a: assert property (@(posedge io_clock_in) disable iff (rst)
    !$past(simple_io_sel_a_n) && simple_io_sel_a_n |-> low_cnt_r >= min_cnt && low_cnt_r <= min_cnt + 6'h0C)
    else $error("cycle length wrong");
  clk_align_a: assert property (@(posedge io_clock_in) disable iff (rst)
    $rose(io_clk_2m_out) || $rose(ref_8m_out) |-> $rose(io_clk_8m_out)) else $error("io clocks out of step");
  strobe_edge_a: assert property (@(posedge io_clock_in) disable iff (rst)
    $fell(io_read_strobe_n) || $fell(io_write_strobe_n) |-> $rose(io_clk_8m_out)) else $error("strobe off 8MHz edge");
  cover property (@(posedge clk_sys) req_done && req.addr[20:19] == 2'h3);
  cover property (@(posedge clk_sys) req_done && req.write);
  cover property (@(posedge clk_sys) req_done && !req.write);
  cover property (@(posedge clk_sys) req_valid && !sel.module_space_sel_n);
endmodule // iosd_decode_asserts

bind iosd_decode iosd_decode_asserts u_iosd_decode_asserts (
  .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req(req), .req_done(req_done), .rdata(rdata),
  .sel(sel), .io_space_hit(io_space_hit), .int_reg_hit(int_reg_hit), .io_clock_in(io_clock_in),
  .io_clk_8m_out(io_clk_8m_out), .io_clk_2m_out(io_clk_2m_out), .ref_8m_out(ref_8m_out),
  .simple_io_sel_a_n(simple_io_sel_a_n), .io_read_strobe_n(io_read_strobe_n),
  .io_write_strobe_n(io_write_strobe_n), .io_data_bus_out(io_data_bus_out), .io_data_bus_oe(io_data_bus_oe));

// ---- tb/iosd_periph_model.sv ----
// slow 16-bit peripheral on the simple i/o bus
`timescale 1ns/1ps
module iosd_periph_model (
  // bus pins
  input  wire logic        io_clock_in,
  input  wire logic        sel_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        oe,
  input  wire logic [15:0] bus_out,
  output logic      [15:0] bus_in,
  // bench side
  input  wire logic [15:0] rd_val,
  output logic      [15:0] wr_seen
);
  logic        rd_cyc = 1'b0;
  logic [15:0] last = 16'h0000;
  // data held until deselect, since the host latches on the edge where the strobe rises
  assign bus_in = oe ? bus_out : ((rd_cyc || (!sel_n && !rd_n)) ? rd_val : ~last);
  always @(posedge io_clock_in) begin
    last <= bus_in;
    rd_cyc <= sel_n ? 1'b0 : (rd_cyc || !rd_n);
    if (!sel_n && !wr_n) wr_seen <= bus_in;
  end
endmodule // iosd_periph_model

// ---- tb/tb_top.sv ----
// self-checking bench for the i/o space decoder
`timescale 1ns/1ps
module tb_top;
  import iosd_pkg::*;
  // --
  // pins and bookkeeping
  // --
  logic        clk_sys = 1'b0;
  logic        io_clock_in = 1'b0;
  logic        rst = 1'b1;
  logic        req_valid = 1'b0;
  iosd_req_s   req = '0;
  logic        decode_narrow_strap = 1'b0;
  logic        ext_ready = 1'b0;
  logic        req_done, io_space_hit, int_reg_hit, vid_reg_hit, io_data_bus_oe;
  logic        simple_io_sel_a_n, simple_io_sel_b_n, io_read_strobe_n, io_write_strobe_n;
  logic [31:0] rdata, rnd;
  iosd_sel_s   sel;
  logic [15:0] io_data_bus_in, io_data_bus_out, wr_seen;
  logic [15:0] rd_val = 16'h0000;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  int          err_total = 0;
  int          num_checks = 0;
  int          seed = 32'hd311;
  logic [31:0] dec_addr [14] = '{32'h0300_0000, 32'h0300_8000, 32'h0303_3FFF, 32'h0303_4000, 32'h0301_0000,
    32'h0301_2000, 32'h0302_A000, 32'h0302_B000, 32'h0302_B800, 32'h0800_0000, 32'h0F00_0000, 32'h0320_0000,
    32'h0340_0000, 32'h0500_0000};
  logic [6:0]  dec_s0 [14] = '{7'h3B, 7'h3B, 7'h3B, 7'h3B, 7'h6B, 7'h73, 7'h77, 7'h7A, 7'h79, 7'h5B, 7'h5B,
    7'h7B, 7'h7B, 7'h7B};
  logic [6:0]  dec_s1 [14] = '{7'h3B, 7'h7B, 7'h3B, 7'h7B, 7'h6B, 7'h73, 7'h77, 7'h7A, 7'h79, 7'h5B, 7'h7B,
    7'h7B, 7'h7B, 7'h7B};
  logic [31:0] cyc_base [4] = '{32'h0334_0000, 32'h032C_0000, 32'h0321_0000, 32'h0338_0000};

  initial forever #10 clk_sys = ~clk_sys;
  initial begin
    #3;
    forever #32 io_clock_in = ~io_clock_in;
  end

  iosd_decode i_iosd_decode (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req(req), .req_done(req_done),
    .rdata(rdata), .decode_narrow_strap(decode_narrow_strap), .ext_ready(ext_ready), .sel(sel),
    .io_space_hit(io_space_hit), .int_reg_hit(int_reg_hit), .vid_reg_hit(vid_reg_hit), .io_clock_in(io_clock_in),
    .io_clk_8m_out(), .io_clk_2m_out(), .ref_8m_out(), .simple_io_sel_a_n(simple_io_sel_a_n),
    .simple_io_sel_b_n(simple_io_sel_b_n), .io_read_strobe_n(io_read_strobe_n),
    .io_write_strobe_n(io_write_strobe_n), .io_data_bus_in(io_data_bus_in), .io_data_bus_out(io_data_bus_out),
    .io_data_bus_oe(io_data_bus_oe));
  iosd_periph_model i_iosd_periph_model (.io_clock_in(io_clock_in), .sel_n(simple_io_sel_a_n),
    .rd_n(io_read_strobe_n), .wr_n(io_write_strobe_n), .oe(io_data_bus_oe), .bus_out(io_data_bus_out),
    .bus_in(io_data_bus_in), .rd_val(rd_val), .wr_seen(wr_seen));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    if (err_total == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // one simple cycle; ready is random since such cycles must not wait on it
  task automatic do_cycle(input logic [31:0] a, input logic wr, input logic exp_b_n);
    logic [31:0] wd;
    int          lc;
    wd = $random(seed);
    lc = 0;
    @(negedge clk_sys);
    rd_val = wd[23:8];
    ext_ready = wd[0];
    exp_q.push_back(wr ? {1'b1, 16'h0000, wd[31:16]} : {1'b0, 16'h0000, wd[23:8]});
    req = '{addr: a, wdata: wd, write: wr};
    req_valid = 1'b1;
    for (int t = 0; t < 400 && req_done !== 1'b1; t++) begin
      @(negedge clk_sys);
      if (simple_io_sel_a_n === 1'b0) lc++;
      if (lc == 4) check({31'h0, simple_io_sel_b_n}, {31'h0, exp_b_n});
    end
    check({31'h0, lc >= 4}, 32'h1);
    if (req_done !== 1'b1) begin
      err_total++;
      report_and_stop();
    end
    @(negedge clk_sys);
    req_valid = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask

  // --
  // result monitor
  // --
  initial forever begin
    @(negedge clk_sys);
    if (req_done === 1'b1) begin
      @(negedge clk_sys);
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1_FFFF_FFFF;
      check(e[32] ? {16'h0000, wr_seen} : rdata, e[31:0]);
    end
  end

  // --
  // main sequence
  // --
  initial begin
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    repeat (16) @(negedge clk_sys);
    for (int s = 0; s < 2; s++) begin
      decode_narrow_strap = s[0];
      repeat (6) @(negedge clk_sys);
      for (int i = 0; i < 14; i++) begin
        req_valid = 1'b1;
        req.addr = dec_addr[i];
        #5 check({25'h0, sel}, {25'h0, s[0] ? dec_s1[i] : dec_s0[i]});
        check({29'h0, io_space_hit, int_reg_hit, vid_reg_hit}, {29'h0, dec_addr[i][31:24] == 8'h03,
          dec_addr[i][31:16] == 16'h0320, dec_addr[i][31:20] == 12'h034});
        @(negedge clk_sys);
      end
      req_valid = 1'b0;
    end
    for (int n = 0; n < 16; n++) begin
      rnd = $random(seed);
      if (n == 0 || n == 8) begin
        decode_narrow_strap = n[3];
        repeat (6) @(negedge clk_sys);
      end
      do_cycle(cyc_base[n[1:0]] | {16'h0000, rnd[15:0]}, n[2], n[1] | (n[3] & (rnd[15:14] != 2'h0)));
    end
    repeat (10) @(negedge clk_sys);
    check(exp_q.size(), 32'h0);
    report_and_stop();
  end
endmodule // tb_top
